//--- common/servo_pkg.sv
package servo_pkg;
    // Clock and modulation timing
    localparam int CLK_HZ        = 20_000_000;
    localparam int MOD_HZ        = 70;
    localparam int MOD_STEPS     = 32;
    localparam int STEP_CYCLES   = CLK_HZ / (MOD_HZ * MOD_STEPS);
    localparam int FRAME_PERIODS = 14;
    localparam int FRAME_SAMPLES = FRAME_PERIODS * MOD_STEPS;
    // Converter widths and mid-scale
    localparam int DAC_W = 12;
    localparam int ADC_W = 12;
    localparam logic [11:0] DAC_MID = 12'h800;
    localparam int ACC_W = 33;
    // Frequency lock loop
    localparam int TUNE_W        = 22;
    localparam int TC_SEL_DEF    = 3;
    localparam int TC_BASE_SHIFT = 2;
    localparam int ERR_SHIFT_DEF = 8;
    localparam int AMP_MIN_DEF   = 4096;
    // Phase lock loop
    localparam int TAU1_MIN_EXP = 8;
    localparam int TAU1_MAX_EXP = 22;
    localparam int TAU1_DEF_EXP = 16;
    localparam int DAMP_MAX_SEL = 4;
    localparam int DAMP_DEF_SEL = 2;
    localparam int FREQ_LIMIT   = 2000;
    localparam int REJECT_NS    = 1024;
    localparam int REJECT_MAX   = 256;
    localparam int SLEW_NS_PER_S = 4;
    localparam int FRAC_BITS    = 24;
    // Gain constants: 2*sqrt(1000) and 6/sqrt(1000), even/odd exponents
    localparam logic [15:0] AP_EVEN_Q8  = 16'h3f3f;
    localparam logic [15:0] AP_ODD_Q8   = 16'h5971;
    localparam logic [15:0] PF_EVEN_Q16 = 16'h3093;
    localparam logic [15:0] PF_ODD_Q16  = 16'h44b1;
    typedef enum logic {LOCK_SUSPENDED = 1'b0, LOCK_RUNNING = 1'b1} lock_state_e;
    typedef enum logic {LOOP_ACQUIRE = 1'b0, LOOP_TRACK = 1'b1} loop_state_e;
endpackage

//--- design/pps_pi_loop.sv
`timescale 1ns/1ns
module pps_pi_loop (
    input  wire logic               sys_clk,
    input  wire logic               reset,
    input  wire logic               tagValid,
    input  wire logic signed [31:0] tagValue,
    input  wire logic [4:0]         tau1Exp,
    input  wire logic [2:0]         dampSel,
    input  wire logic               prefilterOn,
    output logic signed [11:0]      freqOut,
    output logic                    freqValid,
    output logic                    tracking,
    output logic                    restart
);
    import servo_pkg::*;
    localparam logic signed [47:0] LIM = 48'(FREQ_LIMIT) <<< FRAC_BITS;

    function automatic logic signed [47:0] sat(input logic signed [47:0] x);
        sat = (x > LIM) ? LIM : ((x < -LIM) ? -LIM : x);
    endfunction

    loop_state_e state;
    logic signed [31:0] lastGood;
    logic [8:0]         badCount;
    logic signed [47:0] avg, integ;
    logic signed [32:0] diff;
    logic               good, slewBad;
    logic [4:0]         half;
    logic [15:0]        pfCoef, apCoef;
    logic signed [47:0] tagFx, filt, nextInt, prop, sum;
    logic signed [63:0] pfProd, apProd;

    // Rejection, pre-filter, PI update
    always_comb begin
        diff    = 33'(tagValue) - 33'(lastGood);
        good    = (diff <= 33'(REJECT_NS)) && (diff >= -33'(REJECT_NS));
        slewBad = (tagValue > (32'(SLEW_NS_PER_S) <<< tau1Exp))
            || (tagValue < -(32'(SLEW_NS_PER_S) <<< tau1Exp));
        half    = tau1Exp >> 1;
        pfCoef  = tau1Exp[0] ? PF_ODD_Q16 : PF_EVEN_Q16;
        apCoef  = tau1Exp[0] ? AP_ODD_Q8 : AP_EVEN_Q8;
        tagFx   = 48'(tagValue) <<< FRAC_BITS;
        pfProd  = 64'(tagFx - avg) * $signed({1'b0, pfCoef});
        if (prefilterOn) begin
            filt = avg + 48'(pfProd >>> (16 + half + 5'(tau1Exp[0])));
        end else begin
            filt = tagFx;
        end
        nextInt = sat(integ - (filt >>> tau1Exp));
        apProd  = (64'(filt) * $signed({1'b0, apCoef})) <<< dampSel;
        prop    = -48'(apProd >>> (10 + half + 5'(tau1Exp[0])));
        sum     = sat(prop + nextInt);
    end

    // Loop state, one update per accepted tag
    always_ff @(posedge sys_clk) begin
        freqValid <= 1'b0;
        restart   <= 1'b0;
        if (reset) begin
            state    <= LOOP_ACQUIRE;
            lastGood <= '0;
            badCount <= '0;
            avg      <= '0;
            integ    <= '0;
            freqOut  <= '0;
            tracking <= 1'b0;
        end else if (tagValid) begin
            case (state)
                LOOP_ACQUIRE: begin
                    lastGood <= tagValue;
                    avg      <= '0;
                    integ    <= 48'(freqOut) <<< FRAC_BITS;
                    badCount <= '0;
                    tracking <= 1'b1;
                    state    <= LOOP_TRACK;
                end
                LOOP_TRACK: begin
                    if (good && slewBad) begin
                        restart  <= 1'b1;
                        tracking <= 1'b0;
                        state    <= LOOP_ACQUIRE;
                    end else if (good) begin
                        lastGood  <= tagValue;
                        badCount  <= '0;
                        avg       <= filt;
                        integ     <= nextInt;
                        freqOut   <= 12'(sum >>> FRAC_BITS);
                        freqValid <= 1'b1;
                    end else if (badCount == 9'(REJECT_MAX - 1)) begin
                        restart  <= 1'b1;
                        tracking <= 1'b0;
                        state    <= LOOP_ACQUIRE;
                    end else begin
                        badCount <= badCount + 9'd1;
                    end
                end
                default: state <= LOOP_ACQUIRE;
            endcase
        end
    end
endmodule

//--- design/atomic_lock_servo.sv
`timescale 1ns/1ns
// Contract
// - 32-step 70 Hz waveform on 12-bit converter
// - Converter updates paced by hardware timer
// - Sample times sine/cosine at 70, 140 Hz
// - Sum products over 14 modulation periods
// - 70 Hz in-phase sum filtered into tuning
// - Filter coefficient from 1-128 s constant
// - Power-up tuning from last locked value
// - No resonance: hold tuning value constant
// - Suspend on any of five fault conditions
// - Optional pre-filter then PI controller
// - Output count is one part in 1e12
// - Integrator constant power of two, 2^8..2^22
// - Damping power of two 0.25..4, default 1
// - Proportional gain 2 zeta over sqrt(0.001 tau1)
// - Default integrator constant 65536 seconds
// - Natural constant sqrt of 1000 s times tau1
// - Pre-filter on by default, off when prefilterOffSetting is 1
// - Pre-filter averages tags exponentially
// - Loop terms update once per accepted tag
// - Output and integral saturate at 2000
// - Restart after 256 consecutive rejected pulses
module atomic_lock_servo #(
    parameter int STEP_CNT  = servo_pkg::STEP_CYCLES,
    parameter int FRAME_LEN = servo_pkg::FRAME_SAMPLES,
    parameter int ERR_SHIFT = servo_pkg::ERR_SHIFT_DEF,
    parameter int AMP_MIN   = servo_pkg::AMP_MIN_DEF
) (
    input  wire logic                          sys_clk,
    input  wire logic                          reset,
    input  wire logic [servo_pkg::ADC_W-1:0]   adcData,
    input  wire logic                          lampOutOfRange,
    input  wire logic                          synthUnlocked,
    input  wire logic                          agcPinned,
    input  wire logic                          varactorOutOfRange,
    input  wire logic [2:0]                    tcSel,
    input  wire logic [servo_pkg::TUNE_W-1:0]  savedTuning,
    input  wire logic                          tagValid,
    input  wire logic signed [31:0]            tagValue,
    input  wire logic [4:0]                    tau1Exp,
    input  wire logic [2:0]                    dampSel,
    input  wire logic                          prefilterOffSetting,
    output logic [servo_pkg::DAC_W-1:0]        modDac,
    output logic                               dacWrite,
    output logic [servo_pkg::TUNE_W-1:0]       oscillatorTuningValue,
    output logic [servo_pkg::TUNE_W-1:0]       lastLockedTuning,
    output logic                               lockActive,
    output logic                               frameDone,
    output logic signed [servo_pkg::ACC_W-1:0] errorSum,
    output logic signed [11:0]                 setFrequencyCommand,
    output logic                               sfValid,
    output logic                               pllTracking,
    output logic                               pllRestart,
    output logic [4:0]                         tau1Accepted,
    output logic [2:0]                         dampAccepted
);
    import servo_pkg::*;

    // Quarter-wave sine, signed, amplitude 2047
    function automatic logic signed [11:0] sineAt(input logic [4:0] idx);
        logic [2:0]         q;
        logic signed [11:0] m;
        q = idx[3] ? 3'(4'd8 - {1'b0, idx[2:0]}) : idx[2:0];
        case ({idx[3] && idx[2:0] == 3'd0, q})
            4'h0: m = 12'sd0;
            4'h1: m = 12'sd399;
            4'h2: m = 12'sd783;
            4'h3: m = 12'sd1137;
            4'h4: m = 12'sd1447;
            4'h5: m = 12'sd1702;
            4'h6: m = 12'sd1891;
            4'h7: m = 12'sd2008;
            default: m = 12'sd2047;
        endcase
        sineAt = idx[4] ? -m : m;
    endfunction

    function automatic logic signed [ACC_W-1:0] absAcc(input logic signed [ACC_W-1:0] x);
        absAcc = x[ACC_W-1] ? -x : x;
    endfunction

    // Synchronisers for off-chip levels and converter data
    logic [ADC_W-1:0] adcMeta, adcSync;
    logic [3:0]       faultMeta, faultSync;
    always_ff @(posedge sys_clk) begin
        adcMeta   <= adcData;
        adcSync   <= adcMeta;
        faultMeta <= {lampOutOfRange, synthUnlocked, agcPinned, varactorOutOfRange};
        faultSync <= faultMeta;
    end

    // Sample timer, one-cycle step enable
    logic [13:0] stepCnt;
    logic        stepTick;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stepCnt  <= '0;
            stepTick <= 1'b0;
        end else if (stepCnt == 14'(STEP_CNT - 1)) begin
            stepCnt  <= '0;
            stepTick <= 1'b1;
        end else begin
            stepCnt  <= stepCnt + 14'd1;
            stepTick <= 1'b0;
        end
    end

    // Modulation phase index and converter write
    logic [4:0] phase;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phase    <= '0;
            modDac   <= DAC_MID;
            dacWrite <= 1'b0;
        end else begin
            dacWrite <= stepTick;
            if (stepTick) begin
                modDac <= DAC_MID + 12'(sineAt(phase));
                phase  <= phase + 5'd1;
            end
        end
    end

    // Reference products for this step
    logic signed [11:0]      sample;
    logic signed [23:0]      pS70, pC70, pS140, pC140;
    logic [4:0]              phase2;
    always_comb begin
        sample = $signed(adcSync ^ DAC_MID);
        phase2 = {phase[3:0], 1'b0};
        pS70   = sample * sineAt(phase);
        pC70   = sample * sineAt(phase + 5'd8);
        pS140  = sample * sineAt(phase2);
        pC140  = sample * sineAt(phase2 + 5'd8);
    end

    // Frame accumulation over whole modulation periods
    logic signed [ACC_W-1:0] accS70, accC70, accS140, accC140;
    logic signed [ACC_W-1:0] sumS140, sumC140;
    logic [8:0]              sampleCnt;
    always_ff @(posedge sys_clk) begin
        frameDone <= 1'b0;
        if (reset) begin
            accS70    <= '0;
            accC70    <= '0;
            accS140   <= '0;
            accC140   <= '0;
            sampleCnt <= '0;
            errorSum  <= '0;
            sumS140   <= '0;
            sumC140   <= '0;
        end else if (stepTick) begin
            if (sampleCnt == 9'(FRAME_LEN - 1)) begin
                errorSum  <= accS70 + ACC_W'(pS70);
                sumS140   <= accS140 + ACC_W'(pS140);
                sumC140   <= accC140 + ACC_W'(pC140);
                accS70    <= '0;
                accC70    <= '0;
                accS140   <= '0;
                accC140   <= '0;
                sampleCnt <= '0;
                frameDone <= 1'b1;
            end else begin
                accS70    <= accS70 + ACC_W'(pS70);
                accC70    <= accC70 + ACC_W'(pC70);
                accS140   <= accS140 + ACC_W'(pS140);
                accC140   <= accC140 + ACC_W'(pC140);
                sampleCnt <= sampleCnt + 9'd1;
            end
        end
    end

    // Suspend conditions
    logic ampLow, suspend;
    always_comb begin
        ampLow  = (absAcc(sumS140) + absAcc(sumC140)) < ACC_W'(AMP_MIN);
        suspend = ampLow || (|faultSync);
    end

    // Lock state, decided at each frame end
    lock_state_e lockState;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lockState  <= LOCK_SUSPENDED;
            lockActive <= 1'b0;
        end else if (frameDone) begin
            case (lockState)
                LOCK_SUSPENDED: lockState <= suspend ? LOCK_SUSPENDED : LOCK_RUNNING;
                LOCK_RUNNING:   lockState <= suspend ? LOCK_SUSPENDED : LOCK_RUNNING;
                default:        lockState <= LOCK_SUSPENDED;
            endcase
            lockActive <= !suspend;
        end
    end

    // First-order recursive filter on the in-phase error
    logic signed [ACC_W-1:0] errFilt;
    logic signed [ACC_W-1:0] next_errFilt;
    logic signed [34:0]      next_tune;
    always_comb begin
        next_errFilt = errFilt
            + ((errorSum - errFilt) >>> (4'(tcSel) + 4'(TC_BASE_SHIFT)));
        next_tune    = 35'($signed({1'b0, oscillatorTuningValue}))
            - 35'(next_errFilt >>> ERR_SHIFT);
        if (next_tune < 0) begin
            next_tune = '0;
        end else if (next_tune > 35'((1 << TUNE_W) - 1)) begin
            next_tune = 35'((1 << TUNE_W) - 1);
        end
    end

    // Tuning value, loaded from stored value at power-up
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            oscillatorTuningValue <= savedTuning;
            lastLockedTuning      <= savedTuning;
            errFilt               <= '0;
        end else if (frameDone && lockState == LOCK_RUNNING && !suspend) begin
            errFilt               <= next_errFilt;
            oscillatorTuningValue <= TUNE_W'(next_tune);
            lastLockedTuning      <= TUNE_W'(next_tune);
        end
    end

    // Loop settings accepted only when legal
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tau1Accepted <= 5'(TAU1_DEF_EXP);
            dampAccepted <= 3'(DAMP_DEF_SEL);
        end else begin
            if (tau1Exp >= 5'(TAU1_MIN_EXP) && tau1Exp <= 5'(TAU1_MAX_EXP)) begin
                tau1Accepted <= tau1Exp;
            end
            if (dampSel <= 3'(DAMP_MAX_SEL)) begin
                dampAccepted <= dampSel;
            end
        end
    end

    // Phase lock loop to the external pulse
    logic signed [11:0] loopFreq;
    logic               loopValid, loopTrack, loopRestart;
    pps_pi_loop u_loop (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .tagValid    (tagValid),
        .tagValue    (tagValue),
        .tau1Exp     (tau1Accepted),
        .dampSel     (dampAccepted),
        .prefilterOn (!prefilterOffSetting),
        .freqOut     (loopFreq),
        .freqValid   (loopValid),
        .tracking    (loopTrack),
        .restart     (loopRestart)
    );

    // Registered loop outputs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            setFrequencyCommand <= '0;
            sfValid             <= 1'b0;
            pllTracking         <= 1'b0;
            pllRestart          <= 1'b0;
        end else begin
            sfValid     <= loopValid;
            pllTracking <= loopTrack;
            pllRestart  <= loopRestart;
            if (loopValid) begin
                setFrequencyCommand <= loopFreq;
            end
        end
    end
endmodule

//--- verification/servo_asserts.sv
`timescale 1ns/1ns
module servo_asserts #(
    parameter int STEP_CNT  = 4,
    parameter int FRAME_LEN = 64
) (
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    input  wire logic [servo_pkg::DAC_W-1:0]  modDac,
    input  wire logic                         dacWrite,
    input  wire logic [servo_pkg::TUNE_W-1:0] oscillatorTuningValue,
    input  wire logic                         lockActive,
    input  wire logic                         frameDone,
    input  wire logic                         tagValid,
    input  wire logic signed [11:0]           setFrequencyCommand,
    input  wire logic                         sfValid,
    input  wire logic                         pllTracking,
    input  wire logic                         pllRestart,
    input  wire logic [4:0]                   tau1Accepted,
    input  wire logic [2:0]                   dampAccepted
);
    import servo_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    int   stepGap;
    int   frameGap;
    logic stepSeen;
    logic frameSeen;

    // Cycles since the last converter update
    always_ff @(posedge sys_clk) begin
        if (reset || dacWrite) begin
            stepGap  <= 0;
        end else begin
            stepGap <= stepGap + 1;
        end
        stepSeen <= !reset && (stepSeen || dacWrite);
    end

    // Cycles since the last frame end
    always_ff @(posedge sys_clk) begin
        if (reset || frameDone) begin
            frameGap <= 0;
        end else begin
            frameGap <= frameGap + 1;
        end
        frameSeen <= !reset && (frameSeen || frameDone);
    end

    // Multi-step relations
    sequence trackDrop;
        ##1 !pllTracking;
    endsequence
    sequence tagTwoBack;
        $past(tagValid, 2);
    endsequence

    step_period_a: assert property (dacWrite && stepSeen |-> stepGap == STEP_CNT - 1)
        else $error("converter update spacing wrong");
    mod_hold_a: assert property (!dacWrite |-> $stable(modDac))
        else $error("modulation code moved without update");
    frame_period_a: assert property (frameDone && frameSeen |->
        frameGap == STEP_CNT * FRAME_LEN - 1)
        else $error("frame length wrong");
    lock_on_frame_a: assert property ($changed(lockActive) |-> $past(frameDone))
        else $error("lock state changed off frame end");
    tune_when_locked_a: assert property ($changed(oscillatorTuningValue) |->
        lockActive && $past(frameDone))
        else $error("tuning moved while suspended");
    sf_after_tag_a: assert property (sfValid |-> tagTwoBack)
        else $error("frequency output without a tag");
    sf_only_valid_a: assert property ($changed(setFrequencyCommand) |-> sfValid)
        else $error("frequency output changed unflagged");
    freq_range_a: assert property (setFrequencyCommand <= 2000 &&
        setFrequencyCommand >= -2000)
        else $error("frequency output out of range");
    restart_drops_a: assert property (pllRestart |-> trackDrop)
        else $error("tracking stayed up after restart");
    setting_range_a: assert property (tau1Accepted inside {[8:22]} &&
        dampAccepted <= 3'h4)
        else $error("illegal loop setting in use");
endmodule

bind atomic_lock_servo servo_asserts #(.STEP_CNT(STEP_CNT), .FRAME_LEN(FRAME_LEN))
    i_servo_asserts (.*);

//--- verification/pps_reference.sv
`timescale 1ns/1ns
module pps_reference (
    input  wire logic               sys_clk,
    input  wire logic               fire,
    input  wire logic signed [31:0] offsetNs,
    output logic                    tagValid,
    output logic signed [31:0]      tagValue
);
    logic signed [31:0] lastTag;

    // One tag per pulse in ns; stale value inverted so it never looks current
    always_ff @(posedge sys_clk) begin
        tagValid <= fire;
        if (fire) begin
            lastTag  <= offsetNs;
            tagValue <= offsetNs;
        end else begin
            tagValue <= ~lastTag;
        end
    end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import servo_pkg::*;
    logic                sys_clk             = 1'b0;
    logic                reset               = 1'b1;
    logic [11:0]         adcData             = 12'h800;
    logic [3:0]          fault               = 4'h0;
    logic [2:0]          tcSel               = 3'h0;
    logic [2:0]          dampSel             = 3'h2;
    logic [21:0]         savedTuning         = 22'h200000;
    logic [4:0]          tau1Exp             = 5'h10;
    logic                prefilterOffSetting = 1'b0;
    logic                fire                = 1'b0;
    logic signed [31:0]  offsetNs            = 32'sh0;
    logic [4:0]          phase               = 5'h0;
    logic [1:0]          adcMode             = 2'h0;
    logic signed [31:0]  tagValue;
    logic                tagValid, dacWrite, lockActive, frameDone, sfValid;
    logic                pllTracking, pllRestart;
    logic [11:0]         modDac;
    logic [21:0]         oscillatorTuningValue, lastLockedTuning;
    logic signed [32:0]  errorSum;
    logic signed [11:0]  setFrequencyCommand;
    logic [4:0]          tau1Accepted;
    logic [2:0]          dampAccepted;
    wire logic           lampOutOfRange      = fault[0];
    wire logic           synthUnlocked       = fault[1];
    wire logic           agcPinned           = fault[2];
    wire logic           varactorOutOfRange  = fault[3];
    int                  errors              = 0;
    int                  testsRun            = 0;

    atomic_lock_servo #(.STEP_CNT(4), .FRAME_LEN(64)) i_atomic_lock_servo (.*);
    pps_reference i_pps_reference (.*);

    // 20 MHz clock
    initial forever #25 sys_clk = ~sys_clk;

    // Photosignal: optional 140 Hz and 70 Hz squares keyed to converter steps
    always @(posedge sys_clk) begin
        if (dacWrite) begin
            phase   <= phase + 5'h1;
            adcData <= 12'h800 + (adcMode[0] ? (phase[3] ? 12'hc00 : 12'h400) : 12'h0)
                               + (adcMode[1] ? (phase[4] ? 12'he00 : 12'h200) : 12'h0);
        end
    end

    task automatic check(input logic signed [31:0] got, input logic signed [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic waitFrames(input int n);
        repeat (n) @(posedge frameDone);
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic sendTag(input int ns, output logic got, output logic signed [11:0] sf);
        @(posedge sys_clk);
        fire     <= 1'b1;
        offsetNs <= ns;
        @(posedge sys_clk);
        fire <= 1'b0;
        // Output pulses stand one cycle, two edges after the tag pulse
        repeat (2) @(posedge sys_clk);
        #1;
        got = sfValid;
        sf  = setFrequencyCommand;
    endtask

    task automatic testReset();
        check(modDac, 12'h800);
        check(oscillatorTuningValue, savedTuning);
        check(tau1Accepted, 16);
        check(dampAccepted, 2);
    endtask

    task automatic testSettings();
        int v [4] = '{23, 7, 22, 8};
        int r [4] = '{16, 16, 22, 8};
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk) tau1Exp <= 5'(v[i]);
            repeat (3) @(posedge sys_clk);
            #1 check(tau1Accepted, r[i]);
        end
        for (int i = 5; i >= 0; i--) begin
            @(posedge sys_clk) dampSel <= 3'(i);
            repeat (3) @(posedge sys_clk);
            #1 check(dampAccepted, (i == 5) ? 2 : i);
        end
        @(posedge sys_clk) dampSel <= 3'h2;
    endtask

    task automatic testModulation();
        logic [11:0] wave [32];
        for (int i = 0; i < 64; i++) begin
            @(posedge dacWrite);
            #1;
            if (i < 32) wave[i] = modDac;
            else check(modDac, wave[i-32]);
        end
        for (int i = 0; i < 16; i++) check(12'(wave[i] + wave[i+16]), 12'h0);
    endtask

    task automatic testLock();
        logic [21:0] held;
        waitFrames(3);
        check(lockActive, 0);
        check(oscillatorTuningValue, savedTuning);
        @(posedge sys_clk) adcMode <= 2'h1;
        waitFrames(3);
        check(lockActive, 1);
        check(32'(errorSum), 0);
        @(posedge sys_clk) adcMode <= 2'h3;
        waitFrames(4);
        check(errorSum > 0 ? oscillatorTuningValue < savedTuning
                           : oscillatorTuningValue > savedTuning, 1);
        check(lastLockedTuning, oscillatorTuningValue);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk) fault <= 4'h1 << i;
            waitFrames(2);
            held = oscillatorTuningValue;
            waitFrames(2);
            check(lockActive, 0);
            check(oscillatorTuningValue, held);
            @(posedge sys_clk) fault <= 4'h0;
            waitFrames(2);
            check(lockActive, 1);
        end
    endtask

    task automatic testPll();
        logic               ok;
        logic signed [11:0] sf;
        sendTag(100, ok, sf);
        check(ok, 0);
        check(pllTracking, 1);
        sendTag(100, ok, sf);
        check(ok, 1);
        check(sf, -5);
        @(posedge sys_clk) prefilterOffSetting <= 1'b1;
        sendTag(100, ok, sf);
        check(sf, -396);
        sendTag(1000, ok, sf);
        check(sf, -2000);
        for (int i = 0; i < 255; i++) sendTag(5000, ok, sf);
        check(ok, 0);
        check(pllTracking, 1);
        sendTag(5000, ok, sf);
        check(pllRestart, 1);
        check(pllTracking, 0);
        sendTag(1000, ok, sf);
        sendTag(1500, ok, sf);
        check(pllRestart, 1);
    endtask

    task automatic printVerdict();
        $display("Comparisons %0d, mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        printVerdict();
    end

    // Main sequence
    initial begin
        repeat (11) @(posedge sys_clk);
        #1 testReset();
        @(posedge sys_clk) reset <= 1'b0;
        testSettings();
        testModulation();
        testLock();
        testPll();
        printVerdict();
    end
endmodule
